// *** flash_cmd_launch_ecc_capture.sv ***
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module flash_cmd_launch_ecc_capture
#(
    parameter int DIV_W = flash_cmd_pkg::DIV_W_DEF
)
(
    // APB slave
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [flash_cmd_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    // Memory controller
    output flash_cmd_pkg::cmd_params_t            cmd_params,
    output logic                                  cmd_launch,
    input  wire logic                             cmd_done,
    input  wire logic                             res_we,
    input  wire logic [2:0]                       res_idx,
    input  wire logic [15:0]                      res_data,
    input  wire logic                             prot_viol,
    // Array read path
    input  wire flash_cmd_pkg::ecc_fault_t        ecc_fault,
    input  wire logic                             opt_valid,
    input  wire logic [7:0]                       opt_data,
    input  wire logic                             opt_dbe,
    // Derived outputs
    output logic                                  time_base_tick,
    output logic [7:0]                            option_bits
);
    import flash_cmd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [DIV_W-1:0]           divider_value_ff;
    logic                       divider_loaded_ff;
    logic [DIV_W-1:0]           divcnt_ff;
    logic                       tick_ff;
    logic                       cmd_complete_ff;
    logic                       access_err_ff;
    logic                       prot_err_ff;
    logic [2:0]                 pidx_ff;
    logic [NUM_PARAM-1:0][15:0] param_ff;
    cmd_params_t                cmd_params_ff;
    logic                       launch_ff;
    logic [2:0]                 eidx_ff;
    logic                       sbe_flag_ff;
    logic                       dbe_flag_ff;
    logic                       res_df_ff;
    logic [22:0]                res_addr_ff;
    logic [7:0]                 res_parity_ff;
    logic [3:0][15:0]           res_data_ff;
    logic [7:0]                 option_ff;
    logic                       opt_loaded_ff;
    logic                       pready_ff;
    logic                       pslverr_ff;
    logic [31:0]                prdata_ff;
    logic                       access;
    logic                       wr;
    logic                       wr_div;
    logic                       wr_stat;
    logic                       wr_param;
    logic                       wr_flg;
    logic                       launch_req;
    logic                       nxt_sbe;
    logic                       nxt_dbe;
    logic                       fault_free;
    logic                       capture;
    logic [15:0]                ecc_word;
    logic [15:0]                param_word;
    logic [31:0]                nxt_prdata;
    logic                       nxt_slverr;

    ////////////////////////////////////////////////////////////////////////
    // Output wiring
    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign cmd_params     = cmd_params_ff;
    assign cmd_launch     = launch_ff;
    assign time_base_tick = tick_ff;
    assign option_bits    = option_ff;

    // Write strobes at the completing access edge
    assign access   = psel & penable & pready_ff;
    assign wr       = access & pwrite;
    assign wr_div   = wr & (paddr == OFS_CLKDIV);
    assign wr_stat  = wr & (paddr == OFS_STATUS);
    assign wr_flg   = wr & (paddr == OFS_ECCFLG);
    assign wr_param = wr & (paddr == OFS_PARAM) & cmd_complete_ff & (pidx_ff <= IX_LAST);
    assign launch_req = wr_stat & pwdata[COMPLETE_BIT] & cmd_complete_ff;

    ////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait state, registered answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end
        else
        begin
            pready_ff  <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff & nxt_slverr;
            if (psel & penable & ~pready_ff)
                prdata_ff <= pwrite ? '0 : nxt_prdata;
        end
    end

    // Result window multiplexer
    always_comb
    begin
        unique case (eidx_ff)
            IX_PARITY: ecc_word = {res_parity_ff, 1'b0, res_addr_ff[22:16]};
            IX_ADDR:  ecc_word = res_addr_ff[15:0];
            IX_DATA0: ecc_word = res_data_ff[0];
            IX_DATA1: ecc_word = res_data_ff[1];
            IX_DATA2: ecc_word = res_data_ff[2];
            IX_DATA3: ecc_word = res_data_ff[3];
            default:  ecc_word = WORD_ZERO;
        endcase
        param_word = (pidx_ff <= IX_LAST) ? param_ff[pidx_ff] : WORD_ZERO;
    end

    // Read decode; unmapped addresses answer with an error
    always_comb
    begin
        nxt_prdata = '0;
        nxt_slverr = 1'b0;
        unique case (paddr)
            OFS_CLKDIV:
            begin
                nxt_prdata[DIV_W-1:0]  = divider_value_ff;
                nxt_prdata[DIV_LD_BIT] = divider_loaded_ff;
            end
            OFS_STATUS:
            begin
                nxt_prdata[COMPLETE_BIT]   = cmd_complete_ff;
                nxt_prdata[ACCESS_ERR_BIT] = access_err_ff;
                nxt_prdata[PROT_ERR_BIT]   = prot_err_ff;
            end
            OFS_PIDX:   nxt_prdata[2:0]  = pidx_ff;
            OFS_PARAM:  nxt_prdata[15:0] = param_word;
            OFS_EIDX:   nxt_prdata[2:0]  = eidx_ff;
            OFS_ECCRES: nxt_prdata[15:0] = ecc_word;
            OFS_OPTION: nxt_prdata[7:0]  = option_ff;
            OFS_RSV2, OFS_RSV3, OFS_RSV4: nxt_prdata = '0;
            OFS_ECCFLG:
            begin
                nxt_prdata[DBE_BIT] = dbe_flag_ff;
                nxt_prdata[SBE_BIT] = sbe_flag_ff;
            end
            default:    nxt_slverr = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock divider register and loaded flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            divider_value_ff  <= '0;
            divider_loaded_ff <= 1'b0;
        end
        else if (wr_div)
        begin
            divider_value_ff  <= pwdata[DIV_W-1:0];
            divider_loaded_ff <= 1'b1;
        end
    end

    // Program time base: one pulse every divider_value+1 cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            divcnt_ff <= '0;
            tick_ff   <= 1'b0;
        end
        else if (!divider_loaded_ff || wr_div)
        begin
            divcnt_ff <= '0;
            tick_ff   <= 1'b0;
        end
        else if (divcnt_ff >= divider_value_ff)
        begin
            divcnt_ff <= '0;
            tick_ff   <= 1'b1;
        end
        else
        begin
            divcnt_ff <= divcnt_ff + 1'b1;
            tick_ff   <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion flag and launch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_complete_ff <= 1'b1;
            launch_ff       <= 1'b0;
        end
        else
        begin
            launch_ff <= launch_req & divider_loaded_ff;
            if (launch_req & divider_loaded_ff)
                cmd_complete_ff <= 1'b0;
            else if (cmd_done & ~cmd_complete_ff)
                cmd_complete_ff <= 1'b1;
        end
    end

    // Error flags: hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            access_err_ff <= 1'b0;
            prot_err_ff   <= 1'b0;
        end
        else
        begin
            access_err_ff <= (access_err_ff & ~(wr_stat & pwdata[ACCESS_ERR_BIT]))
                           | (launch_req & ~divider_loaded_ff);
            prot_err_ff   <= (prot_err_ff & ~(wr_stat & pwdata[PROT_ERR_BIT]))
                           | prot_viol;
        end
    end

    // Parameter index
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pidx_ff <= '0;
        else if (wr & (paddr == OFS_PIDX) & cmd_complete_ff)
            pidx_ff <= pwdata[2:0];
    end

    // Parameter array: software stages, controller returns results
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            param_ff <= '0;
        else if (wr_param)
            param_ff[pidx_ff] <= pwdata[15:0];
        else if (res_we & ~cmd_complete_ff & (res_idx <= IX_LAST))
            param_ff[res_idx] <= res_data;
    end

    // Snapshot handed to the controller at launch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmd_params_ff <= '0;
        else if (launch_req & divider_loaded_ff)
        begin
            cmd_params_ff.words        <= param_ff;
            cmd_params_ff.command_code <= param_ff[IX_PARITY][15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault flags after this cycle's software clear
    always_comb
    begin
        nxt_sbe    = sbe_flag_ff & ~(wr_flg & pwdata[SBE_BIT]);
        nxt_dbe    = dbe_flag_ff & ~(wr_flg & pwdata[DBE_BIT]);
        fault_free = ~nxt_sbe & ~nxt_dbe;
        capture    = fault_free & (ecc_fault.sbe | ecc_fault.dbe);
    end

    // Fault flags, double-bit preferred
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sbe_flag_ff <= 1'b0;
            dbe_flag_ff <= 1'b0;
        end
        else
        begin
            sbe_flag_ff <= nxt_sbe | (capture & ~ecc_fault.dbe);
            dbe_flag_ff <= nxt_dbe | (capture & ecc_fault.dbe);
        end
    end

    // Fault detail capture, written only by the array path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res_df_ff     <= 1'b0;
            res_addr_ff   <= '0;
            res_parity_ff <= '0;
            res_data_ff   <= '0;
        end
        else if (capture)
        begin
            res_df_ff   <= ecc_fault.is_dflash;
            res_addr_ff <= ecc_fault.addr;
            if (ecc_fault.is_dflash)
            begin
                res_parity_ff <= ecc_fault.parity & DF_PARITY_MASK;
                res_data_ff   <= {{3{WORD_ZERO}}, ecc_fault.data[0]};
            end
            else
            begin
                res_parity_ff <= ecc_fault.parity;
                res_data_ff   <= ecc_fault.data;
            end
        end
    end

    // Result window index
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            eidx_ff <= '0;
        else if (wr & (paddr == OFS_EIDX))
            eidx_ff <= pwdata[2:0];
    end

    // Option byte, loaded once after reset release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            option_ff     <= OPT_RESET;
            opt_loaded_ff <= 1'b0;
        end
        else if (opt_valid & ~opt_loaded_ff)
        begin
            option_ff     <= opt_dbe ? OPT_ALL_ONES : opt_data;
            opt_loaded_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (sbe_flag_ff | dbe_flag_ff) & ~wr_flg |=> $stable(res_addr_ff) && $stable(res_data_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("fault details changed while held");

    property p_prio;
        @(posedge pclk) disable iff (!presetn)
        fault_free & ecc_fault.sbe & ecc_fault.dbe |=> dbe_flag_ff & ~sbe_flag_ff;
    endproperty
    a_prio: assert property (p_prio) else $error("single fault beat double fault");

    property p_ro;
        @(posedge pclk) disable iff (!presetn)
        wr & (paddr == OFS_ECCRES) & ~capture |=> $stable(res_parity_ff);
    endproperty
    a_ro: assert property (p_ro) else $error("result window altered by write");

    property p_ix0;
        @(posedge pclk) disable iff (!presetn)
        access & ~pwrite & (paddr == OFS_ECCRES) & (eidx_ff == IX_PARITY) & $stable(res_parity_ff)
        |-> prdata_ff[15:0] == {res_parity_ff, 1'b0, res_addr_ff[22:16]};
    endproperty
    a_ix0: assert property (p_ix0) else $error("index 0 word wrong");

    property p_unused;
        @(posedge pclk) disable iff (!presetn)
        access & ~pwrite & ($past(paddr) == OFS_ECCRES) & ($past(eidx_ff) > IX_LAST) |-> prdata_ff == '0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused index not zero");

    property p_opt;
        @(posedge pclk) disable iff (!presetn)
        opt_valid & opt_dbe & ~opt_loaded_ff |=> option_ff == OPT_ALL_ONES;
    endproperty
    a_opt: assert property (p_opt) else $error("option not forced to ones");

    property p_rsv;
        @(posedge pclk) disable iff (!presetn)
        access & (paddr == OFS_RSV3) |-> prdata_ff == '0 && !pslverr_ff;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved register not zero");

    property p_nodiv;
        @(posedge pclk) disable iff (!presetn)
        launch_req & ~divider_loaded_ff |=> access_err_ff & cmd_complete_ff & ~launch_ff [*2];
    endproperty
    a_nodiv: assert property (p_nodiv) else $error("launch ran without divider");

    property p_lock;
        @(posedge pclk) disable iff (!presetn)
        ~cmd_complete_ff & ~res_we |=> $stable(param_ff);
    endproperty
    a_lock: assert property (p_lock) else $error("parameters changed while busy");

    property p_launch;
        @(posedge pclk) disable iff (!presetn)
        launch_req & divider_loaded_ff |=> launch_ff & ~cmd_complete_ff
        && cmd_params_ff.words == $past(param_ff);
    endproperty
    a_launch: assert property (p_launch) else $error("launch handover wrong");

    property p_done;
        @(posedge pclk) disable iff (!presetn)
        ~cmd_complete_ff & ~cmd_done |=> ~cmd_complete_ff;
    endproperty
    a_done: assert property (p_done) else $error("completion rose early");

    c_launch: cover property (@(posedge pclk) disable iff (!presetn) launch_ff ##[1:50] cmd_complete_ff);
    c_dbe:    cover property (@(posedge pclk) disable iff (!presetn) capture & ecc_fault.dbe);
    c_nodiv:  cover property (@(posedge pclk) disable iff (!presetn) launch_req & ~divider_loaded_ff);
endmodule

// *** flash_cmd_pkg.sv ***
package flash_cmd_pkg;
    // Bus geometry
    localparam int ADDR_W     = 8;
    localparam int DIV_W_DEF  = 7;
    localparam int NUM_PARAM  = 6;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CLKDIV = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PIDX   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PARAM  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_EIDX   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_ECCRES = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_OPTION = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_RSV2   = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_RSV3   = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_RSV4   = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_ECCFLG = 8'h28;

    // Field positions
    localparam int DIV_LD_BIT = 7;
    localparam int COMPLETE_BIT   = 7;
    localparam int ACCESS_ERR_BIT = 5;
    localparam int PROT_ERR_BIT   = 4;
    localparam int DBE_BIT    = 1;
    localparam int SBE_BIT    = 0;

    // Result window indices
    localparam logic [2:0] IX_PARITY = 3'h0;
    localparam logic [2:0] IX_ADDR  = 3'h1;
    localparam logic [2:0] IX_DATA0 = 3'h2;
    localparam logic [2:0] IX_DATA1 = 3'h3;
    localparam logic [2:0] IX_DATA2 = 3'h4;
    localparam logic [2:0] IX_DATA3 = 3'h5;
    localparam logic [2:0] IX_LAST  = 3'h5;

    // Reset and forced values
    localparam logic [7:0] OPT_RESET     = 8'hFF;
    localparam logic [7:0] OPT_ALL_ONES  = 8'hFF;
    localparam logic [7:0] DF_PARITY_MASK = 8'h3F;
    localparam logic [15:0] WORD_ZERO    = 16'h0000;

    // Fault report from the array read path
    typedef struct packed {
        logic             is_dflash;
        logic             dbe;
        logic             sbe;
        logic [22:0]      addr;
        logic [7:0]       parity;
        logic [3:0][15:0] data;
    } ecc_fault_t;

    // Staged parameter words handed over at launch
    typedef struct packed {
        logic [7:0]                 command_code;
        logic [NUM_PARAM-1:0][15:0] words;
    } cmd_params_t;
endpackage

// *** flash_cmd_launch_ecc_capture_tb.sv ***
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
        end \
    end
module flash_cmd_launch_ecc_capture_tb;
    import flash_cmd_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, opt_data, option_bits;
    logic [31:0] pwdata, prdata;
    logic        cmd_launch, cmd_done, res_we, prot_viol, opt_valid, opt_dbe, time_base_tick;
    logic [2:0]  res_idx;
    logic [15:0] res_data;
    ecc_fault_t  ecc_fault;
    cmd_params_t cmd_params, launched;
    int          err_count, n_tests, launches, ticks;
    ////////////////////////////////////////////////////////////////
    // Device under test
    flash_cmd_launch_ecc_capture #(.DIV_W(7)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_params(cmd_params), .cmd_launch(cmd_launch), .cmd_done(cmd_done),
        .res_we(res_we), .res_idx(res_idx), .res_data(res_data), .prot_viol(prot_viol), .ecc_fault(ecc_fault),
        .opt_valid(opt_valid), .opt_data(opt_data), .opt_dbe(opt_dbe), .time_base_tick(time_base_tick),
        .option_bits(option_bits));
    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Launch pulses and time base ticks
    always @(posedge pclk)
    begin
        if (cmd_launch === 1'b1)
        begin
            launches++;
            launched = cmd_params;
        end
        if (time_base_tick === 1'b1)
            ticks++;
    end
    ////////////////////////////////////////////////////////////////
    // APB transfer, one idle cycle before each setup
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        `CHK("pready", 1, int'(n < 20))
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        `CHK(nm, x, q)
    endtask
    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic opt_load(input logic [7:0] d, input logic dbe);
        @(posedge pclk);
        opt_valid <= 1'b1;
        opt_data  <= d;
        opt_dbe   <= dbe;
        @(posedge pclk);
        opt_valid <= 1'b0;
    endtask
    task automatic fault(input logic df, input logic d, input logic s, input logic [22:0] ad,
                         input logic [7:0] pbits, input logic [63:0] wd);
        @(posedge pclk);
        ecc_fault <= '{df, d, s, ad, pbits, wd};
        @(posedge pclk);
        ecc_fault.dbe <= 1'b0;
        ecc_fault.sbe <= 1'b0;
    endtask
    task automatic pulse_in(input int k);
        @(posedge pclk);
        if (k == 0) cmd_done <= 1'b1; else prot_viol <= 1'b1;
        @(posedge pclk);
        cmd_done  <= 1'b0;
        prot_viol <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_option;
        rd(OFS_STATUS, 32'h80, "completion");
        rd(OFS_CLKDIV, 32'h00, "divider");
        opt_load(8'h5A, 1'b0);
        opt_load(8'h11, 1'b0);
        wr(OFS_OPTION, 32'h00);
        rd(OFS_OPTION, 32'h5A, "option");
        `CHK("option pin", 8'h5A, option_bits)
        do_reset;
        opt_load(8'h12, 1'b1);
        rd(OFS_OPTION, 32'hFF, "option dbe");
        `CHK("option pin dbe", 8'hFF, option_bits)
    endtask
    task automatic t_divider;
        wr(OFS_STATUS, 32'h80);
        rd(OFS_STATUS, 32'hA0, "access error");
        `CHK("launches", 0, launches)
        wr(OFS_STATUS, 32'h20);
        wr(OFS_CLKDIV, 32'h31);
        rd(OFS_CLKDIV, 32'hB1, "divider loaded");
        @(negedge pclk);
        ticks = 0;
        repeat (100) @(negedge pclk);
        `CHK("ticks", 2, ticks)
    endtask
    task automatic t_launch;
        wr(OFS_PIDX, 0);
        wr(OFS_PARAM, 32'h0600);
        wr(OFS_PIDX, 6);
        wr(OFS_PARAM, 32'hFFFF);
        rd(OFS_PARAM, 0, "param six");
        wr(OFS_PIDX, 1);
        wr(OFS_PARAM, 32'h1234);
        wr(OFS_STATUS, 32'h80);
        repeat (3) @(posedge pclk);
        `CHK("launches", 1, launches)
        `CHK("command", 8'h06, launched.command_code)
        `CHK("word one", 16'h1234, launched.words[1])
        wr(OFS_PARAM, 32'h5555);
        wr(OFS_STATUS, 32'h80);
        repeat (3) @(posedge pclk);
        `CHK("launches", 1, launches)
        rd(OFS_PARAM, 32'h1234, "locked param");
        @(posedge pclk);
        res_we   <= 1'b1;
        res_idx  <= 3'h1;
        res_data <= 16'hBEEF;
        @(posedge pclk);
        res_we <= 1'b0;
        pulse_in(1);
        rd(OFS_STATUS, 32'h10, "busy");
        pulse_in(0);
        rd(OFS_STATUS, 32'h90, "done");
        rd(OFS_PARAM, 32'hBEEF, "result");
        wr(OFS_STATUS, 32'h10);
    endtask
    task automatic t_ecc;
        logic [15:0] xp [8];
        logic [15:0] xd [8];
        xp = '{16'hC35A, 16'h1234, 16'hA0A0, 16'hB1B1, 16'hC2C2, 16'hD3D3, 0, 0};
        xd = '{16'h3F10, 16'h0042, 16'h7E7E, 0, 0, 0, 0, 0};
        fault(1'b0, 1'b1, 1'b1, 23'h5A_1234, 8'hC3, 64'hD3D3_C2C2_B1B1_A0A0);
        rd(OFS_ECCFLG, 32'h2, "flags");
        fault(1'b0, 1'b0, 1'b1, 23'h01_1111, 8'h00, 64'h0);
        wr(OFS_ECCRES, 32'hFFFF);
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_EIDX, i);
            rd(OFS_ECCRES, xp[i], "pflash word");
        end
        wr(OFS_ECCFLG, 32'h3);
        rd(OFS_ECCFLG, 32'h0, "flags clear");
        fault(1'b1, 1'b0, 1'b1, 23'h10_0042, 8'hFF, 64'h9999_9999_9999_7E7E);
        rd(OFS_ECCFLG, 32'h1, "flags single");
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_EIDX, i);
            rd(OFS_ECCRES, xd[i], "dflash word");
        end
    endtask
    task automatic t_reserved;
        logic [31:0] q;
        logic        e;
        for (int i = 0; i < 3; i++)
        begin
            wr(OFS_RSV2 + 8'(4 * i), 32'hFF);
            rd(OFS_RSV2 + 8'(4 * i), 0, "reserved");
        end
        apb(1'b0, 8'h40, 0, q, e);
        `CHK("slverr", 1'b1, e)
    endtask
    ////////////////////////////////////////////////////////////////
    // Verdict
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #(20 * 20000);
        err_count++;
        give_verdict;
    end
    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, cmd_done, res_we, res_idx, res_data} = '0;
        {prot_viol, opt_valid, opt_data, opt_dbe, ecc_fault} = '0;
        {err_count, n_tests, launches, ticks} = '0;
        do_reset;
        t_option;
        t_divider;
        t_launch;
        t_ecc;
        t_reserved;
        give_verdict;
    end
endmodule
